// ---- design/carry_select_cell_group.sv ----
// Ten-cell carry-select adder/subtractor group with optional accumulator registers.
// Assumes user logic on ref_clk supplies operands and a Wishbone master sets the mode.
`default_nettype none

module carry_select_cell_group #(
    parameter bit HONOR_CHIP_CLEAR = 1'b1
) (
    input  wire logic                                   ref_clk,
    input  wire logic                                   sys_rst,
    input  wire logic                                   wb_cyc_i,
    input  wire logic                                   wb_stb_i,
    input  wire logic                                   wb_we_i,
    input  wire logic [carry_select_pkg::ADDR_W-1:0]    wb_adr_i,
    input  wire logic [3:0]                             wb_sel_i,
    input  wire logic [31:0]                            wb_dat_i,
    output logic      [31:0]                            wb_dat_o,
    output logic                                        wb_ack_o,
    input  wire logic [carry_select_pkg::CELL_COUNT-1:0] operand_a,
    input  wire logic [carry_select_pkg::CELL_COUNT-1:0] operand_b,
    input  wire logic                                   add_sub,
    input  wire logic                                   group_carry_in,
    input  wire logic                                   clock_enable,
    input  wire logic                                   sync_clear,
    input  wire logic                                   sync_load,
    input  wire logic [carry_select_pkg::CELL_COUNT-1:0] load_data,
    input  wire logic                                   async_clear_0,
    input  wire logic                                   async_clear_1,
    input  wire logic                                   async_preset,
    input  wire logic                                   chip_wide_clear_n,
    output logic      [carry_select_pkg::CELL_COUNT-1:0] sum_out,
    output logic                                        carry_out,
    output logic                                        carry_if_zero_out,
    output logic                                        carry_if_one_out
);
    import carry_select_pkg::*;

    // ==========================================================
    // Declarations
    logic                  reg_mode;
    logic                  chain_head;
    logic [START_W-1:0]    start_field;
    logic [CELL_COUNT-1:0] clear_sel;
    logic [START_W-1:0]    start_idx;
    logic                  start_carry;
    logic                  mid_carry;
    logic                  final_carry;
    logic [CELL_COUNT-1:0] b_eff;
    logic [CELL_COUNT-1:0] cin0;
    logic [CELL_COUNT-1:0] cin1;
    logic [CELL_COUNT-1:0] cout0;
    logic [CELL_COUNT-1:0] cout1;
    logic [CELL_COUNT-1:0] prev0;
    logic [CELL_COUNT-1:0] prev1;
    logic [CELL_COUNT-1:0] s0;
    logic [CELL_COUNT-1:0] s1;
    logic [CELL_COUNT-1:0] seg_sel;
    logic [CELL_COUNT-1:0] sum_comb;
    logic [CELL_COUNT-1:0] sum_q;
    logic [CELL_COUNT-1:0] cell_clear;
    logic                  chip_clear;
    logic                  wb_req;
    logic                  wb_write;
    logic                  hit_ctrl;
    logic                  hit_clear_sel;
    logic                  hit_status;
    logic [31:0]           ctrl_word;
    logic [31:0]           clear_sel_word;
    logic [31:0]           status_word;
    logic [31:0]           read_word;

    // ==========================================================
    // Register port decode
    assign wb_req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_write      = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    assign hit_ctrl      = wb_adr_i == CTRL_OFFSET;
    assign hit_clear_sel = wb_adr_i == CLEAR_SEL_OFFSET;
    assign hit_status    = wb_adr_i == STATUS_OFFSET;

    assign ctrl_word = {24'h000000, start_field, 2'h0, chain_head, reg_mode};
    assign clear_sel_word = {22'h000000, clear_sel};
    assign status_word = {20'h00000, mid_carry, final_carry, sum_out};

    assign read_word = hit_ctrl      ? ctrl_word      :
                       hit_clear_sel ? clear_sel_word :
                       hit_status    ? status_word    : 32'h00000000;

    // ==========================================================
    // Register port handshake
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                wb_dat_o <= read_word;
            end
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_mode    <= MODE_RESET;
            chain_head  <= HEAD_RESET;
            start_field <= START_RESET;
        end else if (wb_write && hit_ctrl && wb_sel_i[0]) begin
            reg_mode    <= wb_dat_i[CTRL_MODE_BIT];
            chain_head  <= wb_dat_i[CTRL_HEAD_BIT];
            start_field <= wb_dat_i[CTRL_START_LSB +: START_W];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clear_sel <= CLEAR_SEL_RESET;
        end else if (wb_write && hit_clear_sel) begin
            if (wb_sel_i[0]) begin
                clear_sel[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                clear_sel[9:8] <= wb_dat_i[9:8];
            end
        end
    end

    // ==========================================================
    // Chain head and carry entry
    assign start_idx = (chain_head && start_field < START_W'(CELL_COUNT)) ?
                       start_field : START_W'(0);
    assign start_carry = chain_head ? (group_carry_in | add_sub)
                                    : group_carry_in;
    assign b_eff = operand_b ^ {CELL_COUNT{add_sub}};

    // ==========================================================
    // Assumed carries entering each cell
    assign prev0 = {cout0[CELL_COUNT-2:0], 1'h0};
    assign prev1 = {cout1[CELL_COUNT-2:0], 1'h0};

    always_comb begin
        cin0 = '0;
        cin1 = '0;
        for (int i = 0; i < CELL_COUNT; i++) begin
            if (i < int'(start_idx)) begin
                cin0[i] = 1'h0;
                cin1[i] = 1'h0;
            end else if (i == int'(start_idx) || i == SEGMENT_LEN) begin
                cin0[i] = 1'h0;
                cin1[i] = 1'h1;
            end else begin
                cin0[i] = prev0[i];
                cin1[i] = prev1[i];
            end
        end
    end

    // ==========================================================
    // Logic cells
    for (genvar g = 0; g < CELL_COUNT; g++) begin : g_cell
        carry_cell u_cell (
            .operand_a_bit   (operand_a[g]),
            .operand_b_bit   (b_eff[g]),
            .carry_if_zero   (cin0[g]),
            .carry_if_one    (cin1[g]),
            .sum_if_zero     (s0[g]),
            .sum_if_one      (s1[g]),
            .carry_next_zero (cout0[g]),
            .carry_next_one  (cout1[g])
        );
    end

    // ==========================================================
    // Resolved carries at cells five and ten
    assign mid_carry = (int'(start_idx) >= SEGMENT_LEN) ? start_carry :
                       (start_carry ? cout1[SEGMENT_LEN-1]
                                    : cout0[SEGMENT_LEN-1]);
    assign final_carry = mid_carry ? cout1[CELL_COUNT-1]
                                   : cout0[CELL_COUNT-1];

    assign seg_sel  = {{(CELL_COUNT-SEGMENT_LEN){mid_carry}}, {SEGMENT_LEN{start_carry}}};
    assign sum_comb = (seg_sel & s1) | (~seg_sel & s0);

    assign carry_out         = final_carry;
    assign carry_if_zero_out = cout0[CELL_COUNT-1];
    assign carry_if_one_out  = cout1[CELL_COUNT-1];

    // ==========================================================
    // Register controls
    assign chip_clear = HONOR_CHIP_CLEAR & ~chip_wide_clear_n;
    assign cell_clear = ({CELL_COUNT{async_clear_1}} & clear_sel)
                      | ({CELL_COUNT{async_clear_0}} & ~clear_sel)
                      | {CELL_COUNT{chip_clear}};

    for (genvar g = 0; g < CELL_COUNT; g++) begin : g_reg
        cell_register u_reg (
            .ref_clk      (ref_clk),
            .sys_rst      (sys_rst),
            .async_clear  (cell_clear[g]),
            .async_preset (async_preset),
            .clock_enable (clock_enable),
            .sync_clear   (sync_clear),
            .sync_load    (sync_load),
            .load_bit     (load_data[g]),
            .sum_bit      (sum_comb[g]),
            .q            (sum_q[g])
        );
    end

    assign sum_out = reg_mode ? sum_q : sum_comb;

    // ==========================================================
    // Checks
    sequence quiet_s;
        !async_clear_0 && !async_clear_1 && !async_preset && !chip_clear;
    endsequence

    sequence capture_s;
        reg_mode && clock_enable && !sync_clear && !sync_load;
    endsequence

    sum_exact_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_idx == START_W'(0) |->
            {carry_out, sum_comb} == (11'(operand_a) + 11'(b_eff) + 11'(start_carry)))
        else $error("Group sum does not match the full-adder result.");

    subtract_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        add_sub && chain_head && start_idx == START_W'(0) |->
            sum_comb == 10'(operand_a - operand_b))
        else $error("Subtraction result is not the two's complement difference.");

    mid_carry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_idx == START_W'(0) |->
            mid_carry == ((6'(operand_a[4:0]) + 6'(b_eff[4:0]) + 6'(start_carry)) >> 5))
        else $error("Resolved carry at cell five is wrong.");

    below_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_idx == START_W'(3) |-> sum_comb[2:0] == (operand_a[2:0] ^ b_eff[2:0]))
        else $error("Cells below the chain head took a carry.");

    bypass_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !reg_mode |-> sum_out == sum_comb)
        else $error("Combinational mode does not pass the sum through.");

    accumulate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (capture_s and quiet_s) ##1 (quiet_s and reg_mode) |-> sum_out == $past(sum_comb))
        else $error("Registered sum did not capture the adder output.");

    chip_clear_a: assert property (@(posedge ref_clk)
        chip_clear |-> sum_q == '0)
        else $error("Chip-wide clear did not clear every register.");

    resume_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_clear ##1 (quiet_s and capture_s)) ##1 quiet_s |-> sum_q == $past(sum_comb))
        else $error("Registers did not resume at the first edge after release.");

    wb_ack_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Wishbone acknowledge is not a single cycle.");
endmodule // carry_select_cell_group

`default_nettype wire

// ---- include/carry_select_pkg.sv ----
// Constants shared by the carry-select cell group and its leaf cells.
// Assumes a single 25 MHz clock and a classic Wishbone register port.
`default_nettype none

package carry_select_pkg;
    // ==========================================================
    // Datapath geometry
    localparam int unsigned CELL_COUNT  = 10;
    localparam int unsigned SEGMENT_LEN = 5;
    localparam int unsigned START_W     = 4;
    localparam int unsigned ADDR_W      = 8;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFFSET      = 8'h00;
    localparam logic [7:0] CLEAR_SEL_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET    = 8'h08;

    // ==========================================================
    // Field positions
    localparam int unsigned CTRL_MODE_BIT   = 0;
    localparam int unsigned CTRL_HEAD_BIT   = 1;
    localparam int unsigned CTRL_START_LSB  = 4;
    localparam int unsigned STATUS_CARRY_BIT = 10;
    localparam int unsigned STATUS_MID_BIT  = 11;

    // ==========================================================
    // Reset values
    localparam logic                  MODE_RESET      = 1'h0;
    localparam logic                  HEAD_RESET      = 1'h1;
    localparam logic [START_W-1:0]    START_RESET     = 4'h0;
    localparam logic [CELL_COUNT-1:0] CLEAR_SEL_RESET = 10'h000;
endpackage

`default_nettype wire

// ---- design/carry_cell.sv ----
// One logic cell in arithmetic mode: both sums and both carries at once.
// Assumes the group drives the two assumed carries from the cell below.
`default_nettype none

module carry_cell (
    input  wire logic operand_a_bit,
    input  wire logic operand_b_bit,
    input  wire logic carry_if_zero,
    input  wire logic carry_if_one,
    output logic      sum_if_zero,
    output logic      sum_if_one,
    output logic      carry_next_zero,
    output logic      carry_next_one
);
    import carry_select_pkg::*;

    // ==========================================================
    // Full-adder carry of two bits and a carry.
    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction

    // ==========================================================
    // Both assumed chains are evaluated in parallel.
    assign sum_if_zero     = operand_a_bit ^ operand_b_bit ^ carry_if_zero;
    assign sum_if_one      = operand_a_bit ^ operand_b_bit ^ carry_if_one;
    assign carry_next_zero = majority(operand_a_bit, operand_b_bit, carry_if_zero);
    assign carry_next_one  = majority(operand_a_bit, operand_b_bit, carry_if_one);
endmodule // carry_cell

`default_nettype wire

// ---- design/cell_register.sv ----
// One cell register with asynchronous clear and preset, group-wide sync controls.
// Assumes the group merges the chip-wide clear into async_clear.
`default_nettype none

module cell_register (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic async_clear,
    input  wire logic async_preset,
    input  wire logic clock_enable,
    input  wire logic sync_clear,
    input  wire logic sync_load,
    input  wire logic load_bit,
    input  wire logic sum_bit,
    output logic      q
);
    import carry_select_pkg::*;

    logic preset_only;

    // ==========================================================
    // Storage
    // A preset still held when the clear falls must load the high at once.
    assign preset_only = async_preset & ~async_clear;

    always_ff @(posedge ref_clk or posedge async_clear or posedge preset_only) begin
        if (async_clear) begin
            q <= 1'h0;
        end else if (preset_only) begin
            q <= 1'h1;
        end else if (sys_rst || sync_clear) begin
            q <= 1'h0;
        end else if (sync_load) begin
            q <= load_bit;
        end else if (clock_enable) begin
            q <= sum_bit;
        end
    end

    // ==========================================================
    // Checks
    sequence quiet_s;
        !async_clear && !async_preset;
    endsequence

    clear_wins_a: assert property (@(posedge ref_clk)
        async_clear |-> q == 1'h0)
        else $error("Register not cleared while clear is held.");

    preset_high_a: assert property (@(posedge ref_clk)
        async_preset && !async_clear |-> q == 1'h1)
        else $error("Preset did not load a high.");

    sync_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (quiet_s and sync_clear) ##1 quiet_s |-> q == 1'h0)
        else $error("Synchronous clear missed.");

    sync_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (quiet_s and (sync_load && !sync_clear)) ##1 quiet_s |-> q == $past(load_bit))
        else $error("Synchronous load missed.");
endmodule // cell_register

`default_nettype wire

// ---- tb/user_logic_model.sv ----
// Model of the user logic that feeds operands and register controls to the cell group.
// Assumes one ref_clk shared with the cell group; every change lands just after a rising edge.
`default_nettype none

module user_logic_model (
    input  wire logic       ref_clk,
    output var  logic [9:0] operand_a,
    output var  logic [9:0] operand_b,
    output var  logic       add_sub,
    output var  logic       group_carry_in,
    output var  logic       clock_enable,
    output var  logic       sync_clear,
    output var  logic       sync_load,
    output var  logic [9:0] load_data,
    output var  logic       async_clear_0,
    output var  logic       async_clear_1,
    output var  logic       async_preset,
    output var  logic       chip_wide_clear_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Drivers
    initial begin
        {operand_a, operand_b, add_sub, group_carry_in} = '0;
        {clock_enable, sync_clear, sync_load, load_data} = '0;
        {async_clear_0, async_clear_1, async_preset} = '0;
        chip_wide_clear_n = 1'b1;
    end
    // Operands change only after an edge and hold until the next call.
    task automatic set_ops(input logic [9:0] a, input logic [9:0] b, input logic sub, cin);
        @(posedge ref_clk);
        operand_a <= a;
        operand_b <= b;
        add_sub <= sub;
        group_carry_in <= cin;
    endtask
    task automatic set_ctl(input logic ce, sclr, sld, input logic [9:0] ld,
                           input logic ac0, ac1, pre, cwc_n);
        @(posedge ref_clk);
        {clock_enable, sync_clear, sync_load, load_data} <= {ce, sclr, sld, ld};
        {async_clear_0, async_clear_1, async_preset} <= {ac0, ac1, pre};
        chip_wide_clear_n <= cwc_n;
    endtask
endmodule // user_logic_model

`default_nettype wire

// ---- tb/carry_select_cell_group_tb.sv ----
// Self-checking bench for the carry-select cell group: register bus and datapath.
// Assumes the user logic model drives the datapath controls and the bench drives the bus.
`default_nettype none

module carry_select_cell_group_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import carry_select_pkg::*;
    // ==========================================================
    // Signals
    logic ref_clk = 1'b0, sys_rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, add_sub, cin, ce, sclr, sld, ac0, ac1, pre, cwc_n;
    logic carry_out, cz_out, co_out;
    logic [9:0] opa, opb, ld, sum_out;
    logic [9:0] va [6] = '{10'h3FF, 10'h155, 10'h200, 10'h0AA, 10'h001, 10'h3FF};
    logic [9:0] vb [6] = '{10'h001, 10'h2AA, 10'h200, 10'h0AA, 10'h3FF, 10'h3FF};
    int starts [5] = '{0, 3, 5, 9, 12};
    int num_errors = 0, comparisons = 0;
    always #20 ref_clk = ~ref_clk;
    user_logic_model ulm (.ref_clk(ref_clk), .operand_a(opa), .operand_b(opb),
        .add_sub(add_sub), .group_carry_in(cin), .clock_enable(ce), .sync_clear(sclr),
        .sync_load(sld), .load_data(ld), .async_clear_0(ac0), .async_clear_1(ac1),
        .async_preset(pre), .chip_wide_clear_n(cwc_n));
    carry_select_cell_group #(.HONOR_CHIP_CLEAR(1'b1)) dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .operand_a(opa), .operand_b(opb), .add_sub(add_sub),
        .group_carry_in(cin), .clock_enable(ce), .sync_clear(sclr), .sync_load(sld),
        .load_data(ld), .async_clear_0(ac0), .async_clear_1(ac1), .async_preset(pre),
        .chip_wide_clear_n(cwc_n), .sum_out(sum_out), .carry_out(carry_out),
        .carry_if_zero_out(cz_out), .carry_if_one_out(co_out));
    // ==========================================================
    // Tasks
    task automatic complete_run();
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                           input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        {wb_cyc, wb_stb, wb_we} <= {2'b11, we};
        wb_adr <= adr;
        wb_sel <= sel;
        wb_wdat <= wd;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        {wb_cyc, wb_stb} <= 2'b00;
        if (n >= 20) begin
            num_errors++;
            complete_run();
        end
    endtask
    // Reference: {resolved carry after cell five, final carry, sums}.
    function automatic logic [11:0] model(input logic [9:0] a, b, input logic sub, ci, hd,
                                          input int st);
        logic [9:0] be, s;
        logic c, mid;
        be = sub ? ~b : b;
        if (!hd || st > 9) st = 0;
        c = hd ? (ci | sub) : ci;
        mid = 1'b0;
        for (int i = 0; i < 10; i++) begin
            s[i] = a[i] ^ be[i] ^ ((i >= st) ? c : 1'b0);
            if (i >= st) c = (a[i] & be[i]) | (c & (a[i] ^ be[i]));
            if (i == 4) mid = c;
        end
        return {mid, c, s};
    endfunction
    task automatic run_vec(input logic [9:0] a, b, input logic sub, ci, hd, input int st);
        logic [11:0] e, ez, eo;
        e = model(a, b, sub, ci, hd, st);
        ez = model(a, b, 1'b0, 1'b0, 1'b1, 5);
        eo = model(a, b, 1'b0, 1'b1, 1'b1, 5);
        ulm.set_ops(a, b, sub, ci);
        #1;
        check({22'h0, sum_out}, {22'h0, e[9:0]});
        check({31'h0, carry_out}, {31'h0, e[10]});
        if (st == 0 && !sub && hd) begin
            check({31'h0, cz_out}, {31'h0, ez[10]});
            check({31'h0, co_out}, {31'h0, eo[10]});
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wb_xfer(1'b0, CTRL_OFFSET, 4'hF, 32'h0);
        check(rd, 32'h0000_0002);
        wb_xfer(1'b0, CLEAR_SEL_OFFSET, 4'hF, 32'h0);
        check(rd, 32'h0);
        wb_xfer(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
        wb_xfer(1'b0, 8'h0C, 4'hF, 32'h0);
        check(rd, 32'h0);
        foreach (starts[s]) begin
            wb_xfer(1'b1, CTRL_OFFSET, 4'h1, 32'(starts[s] << 4) | 32'h2);
            for (int k = 0; k < 24; k++) begin
                run_vec(va[k % 6], vb[k % 6], k[3], k[4], 1'b1, starts[s]);
            end
        end
        wb_xfer(1'b1, CTRL_OFFSET, 4'h1, 32'h0000_0030);
        for (int k = 0; k < 24; k++) begin
            run_vec(va[k % 6], vb[k % 6], k[3], k[4], 1'b0, 0);
        end
        wb_xfer(1'b1, CTRL_OFFSET, 4'h1, 32'h0000_0002);
        ulm.set_ops(10'h01F, 10'h001, 1'b0, 1'b0);
        wb_xfer(1'b1, STATUS_OFFSET, 4'hF, 32'h0);
        wb_xfer(1'b0, STATUS_OFFSET, 4'hF, 32'h0);
        check(rd, 32'h0000_0820);
        wb_xfer(1'b1, CTRL_OFFSET, 4'h1, 32'h0000_0003);
        ulm.set_ctl(1'b1, 1'b0, 1'b0, 10'h000, 1'b0, 1'b0, 1'b0, 1'b1);
        ulm.set_ops(10'h0F0, 10'h00F, 1'b0, 1'b0);
        @(posedge ref_clk);
        #1;
        check({22'h0, sum_out}, 32'h0FF);
        ulm.set_ctl(1'b0, 1'b0, 1'b0, 10'h000, 1'b0, 1'b0, 1'b0, 1'b1);
        ulm.set_ops(10'h100, 10'h100, 1'b0, 1'b0);
        @(posedge ref_clk);
        #1;
        check({22'h0, sum_out}, 32'h0FF);
        ulm.set_ctl(1'b1, 1'b0, 1'b1, 10'h2A5, 1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge ref_clk);
        #1;
        check({22'h0, sum_out}, 32'h2A5);
        ulm.set_ctl(1'b1, 1'b1, 1'b1, 10'h2A5, 1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge ref_clk);
        #1;
        check({22'h0, sum_out}, 32'h000);
        wb_xfer(1'b1, CLEAR_SEL_OFFSET, 4'h3, 32'h0000_03E0);
        ulm.set_ctl(1'b0, 1'b0, 1'b0, 10'h000, 1'b0, 1'b0, 1'b1, 1'b1);
        #1;
        check({22'h0, sum_out}, 32'h3FF);
        ulm.set_ctl(1'b0, 1'b0, 1'b0, 10'h000, 1'b0, 1'b1, 1'b1, 1'b1);
        #1;
        check({22'h0, sum_out}, 32'h01F);
        ulm.set_ctl(1'b0, 1'b0, 1'b0, 10'h000, 1'b1, 1'b1, 1'b1, 1'b1);
        #1;
        check({22'h0, sum_out}, 32'h000);
        ulm.set_ctl(1'b0, 1'b0, 1'b0, 10'h000, 1'b0, 1'b0, 1'b1, 1'b1);
        ulm.set_ctl(1'b1, 1'b0, 1'b1, 10'h155, 1'b0, 1'b0, 1'b1, 1'b0);
        #1;
        check({22'h0, sum_out}, 32'h000);
        ulm.set_ctl(1'b1, 1'b0, 1'b0, 10'h000, 1'b0, 1'b0, 1'b0, 1'b1);
        #1;
        check({22'h0, sum_out}, 32'h000);
        @(posedge ref_clk);
        #1;
        check({22'h0, sum_out}, 32'h200);
        @(posedge ref_clk);
        #1;
        check({22'h0, sum_out}, 32'h200);
        complete_run();
    end
endmodule // carry_select_cell_group_tb

`default_nettype wire
